// ===== shared/ucr_cfg.svh
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH
// register byte offsets
`define UCR_OFF_IER 8'h00
`define UCR_OFF_FCR 8'h04
`define UCR_OFF_LCR 8'h08
`define UCR_OFF_IIR 8'h0c
// field positions
`define UCR_IER_SRST 7
`define UCR_IER_TXEN 6
`define UCR_IER_RTSEN 5
`define UCR_IER_DTREN 4
`define UCR_IER_MDM 3
`define UCR_IER_LINE 2
`define UCR_IER_THR 1
`define UCR_IER_RX 0
`define UCR_FCR_TXCLR 2
`define UCR_FCR_RXCLR 1
`define UCR_FCR_EN 0
`define UCR_LCR_BRK 6
`define UCR_LCR_PEN 3
`define UCR_LCR_STOP 2
// reset values
`define UCR_RST_IER 7'h00
`define UCR_RST_FCR 3'h0
`define UCR_RST_LCR 8'h00
// interrupt source codes, iir[3:0]
`define UCR_ID_NONE 4'h1
`define UCR_ID_ADDR 4'he
`define UCR_ID_LINE 4'h6
`define UCR_ID_RX 4'h4
`define UCR_ID_TO 4'hc
`define UCR_ID_THR 4'h2
`define UCR_ID_MDM 4'h0
// idle character times before receive timeout
`define UCR_TO_CHARS 3'h4
`define UCR_RESP_OK 2'h0
`define UCR_RESP_ERR 2'h2
`endif

// ===== shared/ucr_pkg.sv
`default_nettype none
package ucr_pkg;
    typedef enum logic [0:0] {UCR_W_IDLE = 1'b0, UCR_W_RESP = 1'b1} ucr_wr_st_t;
    typedef enum logic [0:0] {UCR_R_IDLE = 1'b0, UCR_R_DATA = 1'b1} ucr_rd_st_t;
endpackage
`default_nettype wire

// ===== rtl/ucr_top.sv
// How it works
// - ier bit 7 write resets the port, self-clears, reads zero
// - ier bits 6..4 gate tx, rts, dtr pins; rts/dtr port zero only
// - ier bits 3..0 enable modem, line, tx-empty, rx-data interrupts
// - fcr [7:6] picks receive trigger 1, 2, 4 or 7 bytes
// - fcr bit 2 flushes transmit queue, shift register kept, self-clears
// - fcr bit 1 flushes receive queue, shift register kept, self-clears
// - fcr bit 0 enables 8-byte queues, else single byte mode
// - lcr bit 7 is plain storage with no effect
// - lcr bit 6 forces break on transmit line
// - lcr [5:4] parity type: odd, even, mark, space
// - lcr bit 3 enables parity generate and check
// - lcr bit 2 selects one or two stop bits
// - lcr [1:0] sets five to eight data bits
// - iir [7:6] read 11 with queues enabled, else 00
// - iir bit 0 high when nothing pending; [3:0] give source code
// - port zero address match is top priority, cleared by iir read or multidrop off
// - line errors raise priority 1, cleared by line status read
// - trigger reached raises priority 2, cleared by buffer reads
// - over 4 idle character times with data raises timeout, cleared by buffer read
// - tx-empty priority 3 on empty or enable rising; iir read or hold write clear
// - port zero modem change flag raises priority 4, cleared by status read
`timescale 1ns/1ps
`default_nettype none
`include "ucr_cfg.svh"
module ucr_top
    import ucr_pkg::*;
#(
    parameter bit IS_PORT0 = 1'b1
)(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // axi4-lite slave
    input  wire logic [7:0] awaddr,
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    input  wire logic       wvalid,
    output logic            wready,
    output logic [1:0]      bresp,
    output logic            bvalid,
    input  wire logic       bready,
    input  wire logic [7:0] araddr,
    input  wire logic       arvalid,
    output logic            arready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    output logic            rvalid,
    input  wire logic       rready,
    // status from the rest of the port
    input  wire logic [3:0] rx_count,
    input  wire logic       rx_char_done,
    input  wire logic       char_time_tick,
    input  wire logic       line_err_evt,
    input  wire logic       line_status_read,
    input  wire logic       rx_buffer_read,
    input  wire logic       tx_hold_empty,
    input  wire logic       tx_hold_write,
    input  wire logic [3:0] modem_change_flags,
    input  wire logic       addr_match_evt,
    input  wire logic       multidrop_enable,
    input  wire logic       flow_ctl_enable,
    // controls to the rest of the port
    output logic            soft_reset,
    output logic            tx_pin_out_enable,
    output logic            req_send_pin_out_enable,
    output logic            terminal_ready_pin_out_enable,
    output logic            queue_enable,
    output logic [1:0]      rx_trigger_level,
    output logic            tx_queue_flush,
    output logic            rx_queue_flush,
    output logic            general_purpose_bit,
    output logic            force_break,
    output logic [1:0]      parity_type,
    output logic            parity_enable,
    output logic            stop_bit_count,
    output logic [1:0]      char_length,
    output logic            rx_trigger_hit,
    output logic            rts_flow_block,
    output logic            irq_pending
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] trig_bytes(input logic en, input logic [1:0] sel);
        logic [3:0] n;
        n = 4'h1;
        if (en)
        begin
            unique case (sel)
                2'h0: n = 4'h1;
                2'h1: n = 4'h2;
                2'h2: n = 4'h4;
                2'h3: n = 4'h7;
            endcase
        end
        return n;
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return a == `UCR_OFF_IER || a == `UCR_OFF_FCR || a == `UCR_OFF_LCR || a == `UCR_OFF_IIR;
    endfunction
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    ucr_wr_st_t wr_st;
    ucr_rd_st_t rd_st;
    logic       aw_held;
    logic       w_held;
    logic [7:0] awaddr_q;
    logic [7:0] wdata_q;
    logic       wlane_q;
    logic [6:0] ier;
    logic [2:0] fcr;
    logic [7:0] lcr;
    logic [7:0] iir_val;
    logic [3:0] cur_code;
    assign awready = wr_st == UCR_W_IDLE && !aw_held;
    assign wready  = wr_st == UCR_W_IDLE && !w_held;
    assign arready = rd_st == UCR_R_IDLE;
    wire do_wr  = wr_st == UCR_W_IDLE && aw_held && w_held;
    wire wr_en  = do_wr && wlane_q;
    wire wr_ier = wr_en && awaddr_q == `UCR_OFF_IER;
    wire wr_fcr = wr_en && awaddr_q == `UCR_OFF_FCR;
    wire wr_lcr = wr_en && awaddr_q == `UCR_OFF_LCR;
    wire rd_go  = arvalid && arready;
    wire rd_iir = rd_go && araddr == `UCR_OFF_IIR;
    // write-only bits read back as zero
    wire [7:0] next_rdata8 =
        araddr == `UCR_OFF_IER ? {1'b0, ier} :
        araddr == `UCR_OFF_FCR ? {fcr[2:1], 5'h00, fcr[0]} :
        araddr == `UCR_OFF_LCR ? lcr :
        araddr == `UCR_OFF_IIR ? iir_val : 8'h00;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_st    <= UCR_W_IDLE;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 8'h00;
            wlane_q  <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `UCR_RESP_OK;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held  <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held  <= 1'b1;
                wdata_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            if (do_wr)
            begin
                wr_st   <= UCR_W_RESP;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= mapped(awaddr_q) ? `UCR_RESP_OK : `UCR_RESP_ERR;
            end
            else if (bvalid && bready)
            begin
                wr_st  <= UCR_W_IDLE;
                bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_st  <= UCR_R_IDLE;
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `UCR_RESP_OK;
        end
        else if (rd_go)
        begin
            rd_st  <= UCR_R_DATA;
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, next_rdata8};
            rresp  <= mapped(araddr) ? `UCR_RESP_OK : `UCR_RESP_ERR;
        end
        else if (rvalid && rready)
        begin
            rd_st  <= UCR_R_IDLE;
            rvalid <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // soft reset returns every control register here to its reset value
    wire srst = wr_ier && wdata_q[`UCR_IER_SRST];
    wire [6:0] ier_wmask = IS_PORT0 ? 7'h7f : 7'h47;
    wire thr_en_rise = wr_ier && wdata_q[`UCR_IER_THR] && !ier[`UCR_IER_THR];
    always_ff @(posedge aclk)
    begin
        if (!aresetn || srst)
        begin
            ier            <= `UCR_RST_IER;
            fcr            <= `UCR_RST_FCR;
            lcr            <= `UCR_RST_LCR;
            tx_queue_flush <= 1'b0;
            rx_queue_flush <= 1'b0;
        end
        else
        begin
            if (wr_ier)
                ier <= wdata_q[6:0] & ier_wmask;
            if (wr_fcr)
                fcr <= {wdata_q[7:6], wdata_q[`UCR_FCR_EN]};
            if (wr_lcr)
                lcr <= wdata_q;
            // flush strobes last one cycle, nothing stored
            tx_queue_flush <= wr_fcr && wdata_q[`UCR_FCR_TXCLR];
            rx_queue_flush <= wr_fcr && wdata_q[`UCR_FCR_RXCLR];
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            soft_reset <= 1'b0;
        else
            soft_reset <= srst;
    end
    assign tx_pin_out_enable             = ier[`UCR_IER_TXEN];
    assign req_send_pin_out_enable       = ier[`UCR_IER_RTSEN];
    assign terminal_ready_pin_out_enable = ier[`UCR_IER_DTREN];
    assign queue_enable     = fcr[0];
    assign rx_trigger_level = fcr[2:1];
    assign general_purpose_bit = lcr[7];
    assign force_break    = lcr[`UCR_LCR_BRK];
    assign parity_type    = lcr[5:4];
    assign parity_enable  = lcr[`UCR_LCR_PEN];
    assign stop_bit_count = lcr[`UCR_LCR_STOP];
    assign char_length    = lcr[1:0];
    // ------------------------------------------------------------
    // interrupt sources
    // ------------------------------------------------------------
    logic       addr_flag;
    logic       line_flag;
    logic       to_flag;
    logic       thr_flag;
    logic       empty_q;
    logic       rts_open;
    logic [2:0] to_cnt;
    // legacy mode behaves as a one byte trigger
    wire [3:0] trig_n = trig_bytes(fcr[0], fcr[2:1]);
    assign rx_trigger_hit = rx_count >= trig_n;
    wire to_hit  = char_time_tick && to_cnt == `UCR_TO_CHARS && !rx_char_done;
    wire to_hold = rx_count == 4'h0 || rx_char_done || rx_buffer_read;
    wire thr_set = (tx_hold_empty && !empty_q) || thr_en_rise;
    wire clr_addr = (rd_iir && cur_code == `UCR_ID_ADDR) || !multidrop_enable;
    wire clr_thr  = (rd_iir && cur_code == `UCR_ID_THR) || tx_hold_write;
    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn || srst)
        begin
            addr_flag <= 1'b0;
            line_flag <= 1'b0;
            to_flag   <= 1'b0;
            thr_flag  <= 1'b0;
            empty_q   <= 1'b0;
            to_cnt    <= 3'h0;
            rts_open  <= 1'b1;
        end
        else
        begin
            empty_q <= tx_hold_empty;
            if (IS_PORT0 && addr_match_evt && multidrop_enable)
                addr_flag <= 1'b1;
            else if (clr_addr)
                addr_flag <= 1'b0;
            if (line_err_evt)
                line_flag <= 1'b1;
            else if (line_status_read)
                line_flag <= 1'b0;
            if (rx_count != 4'h0 && to_hit)
                to_flag <= 1'b1;
            else if (rx_buffer_read)
                to_flag <= 1'b0;
            if (thr_set)
                thr_flag <= 1'b1;
            else if (clr_thr)
                thr_flag <= 1'b0;
            if (to_hold)
                to_cnt <= 3'h0;
            else if (char_time_tick && to_cnt != 3'h7)
                to_cnt <= to_cnt + 3'h1;
            // rts reopens only once the receive queue has drained
            if (rx_trigger_hit)
                rts_open <= 1'b0;
            else if (rx_count == 4'h0)
                rts_open <= 1'b1;
        end
    end
    assign rts_flow_block = flow_ctl_enable && !rts_open;
    wire p_addr = addr_flag;
    wire p_line = ier[`UCR_IER_LINE] && line_flag;
    wire p_rx   = ier[`UCR_IER_RX] && rx_trigger_hit;
    wire p_to   = ier[`UCR_IER_RX] && to_flag;
    wire p_thr  = ier[`UCR_IER_THR] && thr_flag;
    wire p_mdm  = IS_PORT0 && ier[`UCR_IER_MDM] && (|modem_change_flags);
    assign cur_code = p_addr ? `UCR_ID_ADDR :
                      p_line ? `UCR_ID_LINE :
                      p_rx   ? `UCR_ID_RX :
                      p_to   ? `UCR_ID_TO :
                      p_thr  ? `UCR_ID_THR :
                      p_mdm  ? `UCR_ID_MDM : `UCR_ID_NONE;
    assign iir_val = {{2{fcr[0]}}, 2'h0, cur_code};
    assign irq_pending = !cur_code[0];
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_srst;
        @(posedge aclk) disable iff (!aresetn)
        srst |=> ier == 7'h00 && fcr == 3'h0 && soft_reset ##1 !soft_reset;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset did not clear");
    property p_pins;
        @(posedge aclk) disable iff (!aresetn)
        !IS_PORT0 |-> !req_send_pin_out_enable && !terminal_ready_pin_out_enable && !p_mdm;
    endproperty
    a_pins: assert property (p_pins) else $error("port-zero-only bit set");
    property p_trig7;
        @(posedge aclk) disable iff (!aresetn)
        fcr == 3'h7 |-> rx_trigger_hit == (rx_count >= 4'h7);
    endproperty
    a_trig7: assert property (p_trig7) else $error("seven byte trigger wrong");
    property p_rts;
        @(posedge aclk) disable iff (!aresetn || srst)
        flow_ctl_enable && rx_trigger_hit ##1 flow_ctl_enable |-> rts_flow_block;
    endproperty
    a_rts: assert property (p_rts) else $error("rts not dropped at trigger");
    property p_txflush;
        @(posedge aclk) disable iff (!aresetn)
        wr_fcr && wdata_q[2] && !srst |=> tx_queue_flush ##1 !tx_queue_flush;
    endproperty
    a_txflush: assert property (p_txflush) else $error("tx flush not one pulse");
    property p_brk;
        @(posedge aclk) disable iff (!aresetn)
        wr_lcr |=> force_break == $past(wdata_q[6]) && parity_enable == $past(wdata_q[3]);
    endproperty
    a_brk: assert property (p_brk) else $error("line format not loaded");
    property p_fifo_id;
        @(posedge aclk) disable iff (!aresetn)
        rd_iir |=> rdata[7:6] == {2{$past(fcr[0])}} && rdata[0] == !$past(irq_pending);
    endproperty
    a_fifo_id: assert property (p_fifo_id) else $error("iir read value wrong");
    property p_line_prio;
        @(posedge aclk) disable iff (!aresetn || srst)
        line_err_evt && ier[2] && !p_addr ##1 !addr_flag && ier[2] |-> cur_code == 4'h6;
    endproperty
    a_line_prio: assert property (p_line_prio) else $error("line status not reported");
    property p_rx_prio;
        @(posedge aclk) disable iff (!aresetn)
        p_rx && !p_addr && !p_line |-> cur_code == 4'h4;
    endproperty
    a_rx_prio: assert property (p_rx_prio) else $error("rx data not reported");
    property p_timeout;
        @(posedge aclk) disable iff (!aresetn || srst)
        to_cnt == 3'h4 && char_time_tick && !to_hold |=> to_flag;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");
    property p_thr_clr;
        @(posedge aclk) disable iff (!aresetn)
        tx_hold_write && !thr_set |=> !thr_flag;
    endproperty
    a_thr_clr: assert property (p_thr_clr) else $error("tx empty not cleared");
    property p_bhold;
        @(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_lcr);
    c_iir: cover property (@(posedge aclk) disable iff (!aresetn) rd_iir && irq_pending);
    c_to: cover property (@(posedge aclk) disable iff (!aresetn) p_to);
    c_srst: cover property (@(posedge aclk) disable iff (!aresetn) srst);
endmodule // ucr_top
`default_nettype wire

// ===== test/ucr_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module ucr_port_model #(
    parameter int CHAR_CYC = 50
)(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // requests from the bench
    input  wire logic       push,
    input  wire logic       pop,
    // controls from the block
    input  wire logic       soft_reset,
    input  wire logic       rx_queue_flush,
    // status to the block
    output logic [3:0]      rx_count,
    output logic            rx_char_done,
    output logic            rx_buffer_read,
    output logic            char_time_tick
);
    logic [7:0] tick_cnt;

    // ----------------------------------------
    // receive queue, eight deep
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || soft_reset || rx_queue_flush)
            rx_count <= 4'h0;
        else if (push && rx_count < 4'h8)
            rx_count <= rx_count + 4'h1;
        else if (pop && rx_count != 4'h0)
            rx_count <= rx_count - 4'h1;
        rx_char_done   <= aresetn && push;
        rx_buffer_read <= aresetn && pop;
    end

    // ----------------------------------------
    // character time, free running like the baud divider
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick_cnt == 8'(CHAR_CYC - 1))
            tick_cnt <= 8'h00;
        else
            tick_cnt <= tick_cnt + 8'h01;
        char_time_tick <= aresetn && tick_cnt == 8'(CHAR_CYC - 1);
    end
endmodule // ucr_port_model
`default_nettype wire

// ===== test/ucr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ucr_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
`define PULSE(s) @(posedge aclk) s <= 1'b1; @(posedge aclk) s <= 1'b0;
module ucr_top_bench;
    import ucr_pkg::*;
    localparam int CC = 50;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, rx_count, modem_change_flags;
    logic [1:0] bresp, rresp, rx_trigger_level, parity_type, char_length;
    logic rx_char_done, char_time_tick, line_err_evt, line_status_read, rx_buffer_read, tx_hold_empty;
    logic tx_hold_write, addr_match_evt, multidrop_enable, flow_ctl_enable, soft_reset, tx_pin_out_enable;
    logic req_send_pin_out_enable, terminal_ready_pin_out_enable, queue_enable, tx_queue_flush, rx_queue_flush;
    logic general_purpose_bit, force_break, parity_enable, stop_bit_count, rx_trigger_hit, rts_flow_block;
    logic irq_pending, push, pop;
    int n_errors, cmp_count, n_srst, n_txf, n_rxf, k, n;
    logic [7:0] fmt [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
    int trig [4] = '{1, 2, 4, 7};

    ucr_top DUT (.*);
    ucr_port_model #(.CHAR_CYC(CC)) far_side (.aclk, .aresetn, .push, .pop, .soft_reset, .rx_queue_flush,
        .rx_count, .rx_char_done, .rx_buffer_read, .char_time_tick);

    always #2.5 aclk = ~aclk;
    // self-clearing controls are one-cycle pulses, so count them as they pass
    always @(posedge aclk)
    begin
        n_srst += soft_reset;
        n_txf += tx_queue_flush;
        n_rxf += rx_queue_flush;
    end

    // ----------------------------------------
    // axi4-lite master
    // ----------------------------------------
    task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic [1:0] r);
        bit awh, wh, arh, done;
        done = 0;
        q = 8'h00;
        r = 2'h3;
        @(posedge aclk);
        if (w)
        begin
            awaddr  <= a;
            awvalid <= 1'b1;
            wdata   <= {24'h000000, d};
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end
        else
        begin
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        for (int i = 0; i < 64 && !done; i++)
        begin
            @(negedge aclk);
            awh = awvalid && awready;
            wh = wvalid && wready;
            arh = arvalid && arready;
            if (bvalid && bready)
            begin
                r = bresp;
                done = 1;
            end
            if (rvalid && rready)
            begin
                q = rdata[7:0];
                r = rresp;
                done = 1;
            end
            @(posedge aclk);
            if (awh)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
            if (arh)
                arvalid <= 1'b0;
            if (done)
            begin
                bready <= 1'b0;
                rready <= 1'b0;
            end
        end
        if (!done)
        begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic [1:0] r;
        bus(1, a, d, q, r);
        `CHK(r, `UCR_RESP_OK)
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic [1:0] r;
        bus(0, a, 8'h00, q, r);
        `CHK(q, e)
        `CHK(r, `UCR_RESP_OK)
    endtask

    task automatic settle();
        repeat (2) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic npush(input int c);
        repeat (c) begin `PULSE(push) end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [7:0] q;
        logic [1:0] r;
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {line_err_evt, line_status_read, tx_hold_empty, tx_hold_write, addr_match_evt} = '0;
        {multidrop_enable, flow_ctl_enable, push, pop, modem_change_flags} = '0;
        wstrb = 4'h1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`UCR_OFF_IER, 8'h00);
        rchk(`UCR_OFF_FCR, 8'h00);
        rchk(`UCR_OFF_LCR, 8'h00);
        rchk(`UCR_OFF_IIR, 8'h01);
        bus(0, 8'h10, 8'h00, q, r);
        `CHK(r, `UCR_RESP_ERR)
        $display("test reset done");
        foreach (fmt[i])
        begin
            wreg(`UCR_OFF_LCR, fmt[i]);
            rchk(`UCR_OFF_LCR, fmt[i]);
            @(negedge aclk);
            `CHK({general_purpose_bit, force_break, parity_type, parity_enable, stop_bit_count, char_length}, fmt[i])
        end
        $display("test format done");
        wreg(`UCR_OFF_IER, 8'h7f);
        rchk(`UCR_OFF_IER, 8'h7f);
        `CHK({tx_pin_out_enable, req_send_pin_out_enable, terminal_ready_pin_out_enable}, 3'h7)
        wreg(`UCR_OFF_FCR, 8'h41);
        wreg(`UCR_OFF_LCR, 8'h5a);
        k = n_srst;
        wreg(`UCR_OFF_IER, 8'h80);
        settle();
        `CHK(n_srst, k + 1)
        rchk(`UCR_OFF_IER, 8'h00);
        rchk(`UCR_OFF_FCR, 8'h00);
        rchk(`UCR_OFF_LCR, 8'h00);
        `CHK({tx_pin_out_enable, req_send_pin_out_enable, terminal_ready_pin_out_enable}, 3'h0)
        $display("test soft reset done");
        k = n_txf;
        n = n_rxf;
        wreg(`UCR_OFF_FCR, 8'h07);
        settle();
        `CHK(n_txf, k + 1)
        `CHK(n_rxf, n + 1)
        rchk(`UCR_OFF_FCR, 8'h01);
        rchk(`UCR_OFF_IIR, 8'hc1);
        flow_ctl_enable <= 1'b1;
        wreg(`UCR_OFF_IER, 8'h01);
        foreach (trig[i])
        begin
            wreg(`UCR_OFF_FCR, {i[1:0], 6'h03});
            npush(trig[i] - 1);
            settle();
            `CHK(rx_trigger_level, i[1:0])
            `CHK({rx_trigger_hit, rts_flow_block, irq_pending}, 3'h0)
            npush(1);
            settle();
            `CHK({rx_trigger_hit, rts_flow_block, irq_pending}, 3'h7)
            rchk(`UCR_OFF_IIR, 8'hc4);
        end
        wreg(`UCR_OFF_FCR, 8'hc2);
        npush(1);
        settle();
        `CHK({queue_enable, rx_trigger_hit}, 2'h1)
        rchk(`UCR_OFF_IIR, 8'h04);
        $display("test queue control done");
        wreg(`UCR_OFF_IER, 8'h05);
        wreg(`UCR_OFF_FCR, 8'h03);
        npush(1);
        `PULSE(line_err_evt)
        settle();
        rchk(`UCR_OFF_IIR, 8'hc6);
        `PULSE(line_status_read)
        settle();
        rchk(`UCR_OFF_IIR, 8'hc4);
        `PULSE(pop)
        settle();
        rchk(`UCR_OFF_IIR, 8'hc1);
        wreg(`UCR_OFF_FCR, 8'hc3);
        npush(1);
        repeat (4 * CC - 8) @(posedge aclk);
        @(negedge aclk);
        `CHK(irq_pending, 1'b0)
        for (k = 0; k < 3 * CC && irq_pending !== 1'b1; k++) @(negedge aclk);
        // a timeout that never comes must not hang the run
        if (irq_pending !== 1'b1)
        begin
            n_errors++;
            conclude();
        end
        rchk(`UCR_OFF_IIR, 8'hcc);
        `PULSE(pop)
        settle();
        rchk(`UCR_OFF_IIR, 8'hc1);
        $display("test receive irq done");
        multidrop_enable <= 1'b1;
        `PULSE(addr_match_evt)
        settle();
        rchk(`UCR_OFF_IIR, 8'hce);
        rchk(`UCR_OFF_IIR, 8'hc1);
        `PULSE(addr_match_evt)
        multidrop_enable <= 1'b0;
        settle();
        rchk(`UCR_OFF_IIR, 8'hc1);
        wreg(`UCR_OFF_IER, 8'h00);
        @(posedge aclk) tx_hold_empty <= 1'b1;
        settle();
        rchk(`UCR_OFF_IIR, 8'hc1);
        wreg(`UCR_OFF_IER, 8'h02);
        rchk(`UCR_OFF_IIR, 8'hc2);
        rchk(`UCR_OFF_IIR, 8'hc1);
        // holding register refills, then empties again: a fresh rising edge
        @(posedge aclk) tx_hold_empty <= 1'b0;
        @(posedge aclk) tx_hold_empty <= 1'b1;
        settle();
        `CHK(irq_pending, 1'b1)
        `PULSE(tx_hold_write)
        settle();
        `CHK(irq_pending, 1'b0)
        wreg(`UCR_OFF_IER, 8'h08);
        modem_change_flags <= 4'h4;
        settle();
        rchk(`UCR_OFF_IIR, 8'hc0);
        modem_change_flags <= 4'h0;
        settle();
        rchk(`UCR_OFF_IIR, 8'hc1);
        $display("test transmit and modem irq done");
        conclude();
    end
endmodule // ucr_top_bench
`default_nettype wire
